/* src/dmas_pkg.sv */
// constants and types for the debug management and authentication status regs
package dmas_pkg;
    localparam int DMAS_ADDR_W = 12;
    localparam int DMAS_DATA_W = 32;
    localparam int DMAS_FIELD_COUNT = 8;
    localparam int DMAS_FIELD_BASE_BIT = 12;
    localparam int DMAS_RESERVED_LSB = 28;
    localparam logic [11:0] DMAS_MGMT_FIRST = 12'hF00;
    localparam logic [11:0] DMAS_MGMT_LAST = 12'hFCC;
    localparam logic [11:0] DMAS_FRAME_LAST = 12'hFFF;
    localparam logic [11:0] DMAS_AUTH_STATUS_OFFSET = 12'hFB8;
    localparam logic [3:0] DMAS_COMPONENT_CLASS = 4'h9;
    localparam logic [1:0] DMAS_CODE_ABSENT = 2'h0;
    localparam logic [1:0] DMAS_CODE_RESERVED = 2'h1;
    localparam logic [1:0] DMAS_CODE_DISABLED = 2'h2;
    localparam logic [1:0] DMAS_CODE_ENABLED = 2'h3;
    localparam logic [1:0] DMAS_RESP_OKAY = 2'h0;
    localparam logic [1:0] DMAS_RESP_SLVERR = 2'h2;
    localparam logic [31:0] DMAS_AUTH_RESET = 32'h00000000;
    localparam int DMAS_SETTLE_CYCLES = 5;

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic [1:0] code;
    } dmas_field_s;

    localparam dmas_field_s DMAS_FIELD_RESET = '0;

    typedef struct packed {
        logic awHeld;
        logic [11:0] awAddr;
        logic wHeld;
        logic bValid;
        logic [1:0] bResp;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
        logic [31:0] authentication_status;
        logic [3:0] componentClass;
        logic [11:0] partNumber;
    } dmas_top_s;

    localparam dmas_top_s DMAS_TOP_RESET = '0;
endpackage

/* src/dmas_field_if.sv */
// one status field code passed from an encoder to the register bank
`timescale 1ns/1ns
interface dmas_field_if;
    logic [1:0] code;
    modport enc
    (
        output code
    );
    modport bank
    (
        input code
    );
endinterface

/* src/dmas_field_enc.sv */
// synchronises one enable pin and encodes its two-bit status field
`timescale 1ns/1ns
module dmas_field_enc
    import dmas_pkg::*;
#(
    parameter bit IMPLEMENTED = 1'b1
)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic enablePin,
    dmas_field_if.enc fieldIo
);
    dmas_field_s st;
    dmas_field_s next_st;

    always_comb
    begin
        next_st = st;
        next_st.sync1 = enablePin;
        next_st.sync2 = st.sync1;
        // absent field reads 0b00, else 0b10 or 0b11, never 0b01
        if (IMPLEMENTED)
        begin
            next_st.code = st.sync2 ? DMAS_CODE_ENABLED : DMAS_CODE_DISABLED;
        end
        else
        begin
            next_st.code = DMAS_CODE_ABSENT;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            st <= DMAS_FIELD_RESET;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign fieldIo.code = st.code;
endmodule

/* src/dmas_regs.sv */
// management register region with live authentication status over axi4-lite
`timescale 1ns/1ns
module dmas_regs
    import dmas_pkg::*;
#(
    parameter logic [7:0] FIELD_IMPL = 8'hFF,
    // arbitrary part number value
    parameter logic [11:0] PART_NUMBER = 12'h5A1
)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] debugEnable,
    input wire logic [11:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [11:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic [3:0] componentClass,
    output logic [11:0] partNumber
);
    dmas_top_s st;
    dmas_top_s next_st;
    logic [1:0] fieldCode [DMAS_FIELD_COUNT];

    // field 0 is realm invasive at bit 12, field 7 root non-invasive at 26
    for (genvar i = 0; i < DMAS_FIELD_COUNT; i++)
    begin : g_field
        dmas_field_if fieldIf ();
        dmas_field_enc #(
            .IMPLEMENTED(FIELD_IMPL[i])
        ) u_enc (
            .clk(clk),
            .rst_b(rst_b),
            .enablePin(debugEnable[i]),
            .fieldIo(fieldIf)
        );
        assign fieldCode[i] = fieldIf.code;
    end

    // frame below the management range holds nothing here
    function automatic logic [1:0] respFor(input logic [11:0] addr);
        respFor = (addr < DMAS_MGMT_FIRST) ? DMAS_RESP_SLVERR : DMAS_RESP_OKAY;
    endfunction

    function automatic logic [31:0] readFor(input logic [11:0] addr,
                                            input logic [31:0] auth);
        readFor = '0;
        if ({addr[11:2], 2'h0} == DMAS_AUTH_STATUS_OFFSET)
        begin
            readFor = auth;
        end
    endfunction

    assign awready = !st.awHeld && !st.bValid;
    assign wready = !st.wHeld && !st.bValid;
    assign arready = !st.rValid;

    always_comb
    begin
        next_st = st;
        next_st.componentClass = DMAS_COMPONENT_CLASS;
        next_st.partNumber = PART_NUMBER;
        next_st.authentication_status = DMAS_AUTH_RESET;
        for (int i = 0; i < DMAS_FIELD_COUNT; i++)
        begin
            next_st.authentication_status[DMAS_FIELD_BASE_BIT + 2 * i +: 2] =
                fieldCode[i];
        end
        if (awvalid && awready)
        begin
            next_st.awHeld = 1'b1;
            next_st.awAddr = awaddr;
        end
        if (wvalid && wready)
        begin
            next_st.wHeld = 1'b1;
        end
        // data and strobes are dropped: nothing here is writable
        if (next_st.awHeld && next_st.wHeld && !st.bValid)
        begin
            next_st.awHeld = 1'b0;
            next_st.wHeld = 1'b0;
            next_st.bValid = 1'b1;
            next_st.bResp = respFor(next_st.awAddr);
        end
        if (st.bValid && bready)
        begin
            next_st.bValid = 1'b0;
        end
        if (st.rValid && rready)
        begin
            next_st.rValid = 1'b0;
        end
        if (arvalid && arready)
        begin
            next_st.rValid = 1'b1;
            next_st.rData = readFor(araddr, st.authentication_status);
            next_st.rResp = respFor(araddr);
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            st <= DMAS_TOP_RESET;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign bvalid = st.bValid;
    assign bresp = st.bResp;
    assign rvalid = st.rValid;
    assign rdata = st.rData;
    assign rresp = st.rResp;
    assign componentClass = st.componentClass;
    assign partNumber = st.partNumber;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    AST_CLASS_NINE: assert property (
        $past(rst_b) |-> componentClass == DMAS_COMPONENT_CLASS)
        else $error("component class is not nine");

    AST_AUTH_IN_MGMT: assert property (
        (arvalid && arready && araddr >= DMAS_MGMT_FIRST
            && araddr <= DMAS_MGMT_LAST) |=> rresp == DMAS_RESP_OKAY)
        else $error("management range read not answered okay");

    AST_ZERO_UNMAPPED: assert property (
        (arvalid && arready && araddr >= DMAS_MGMT_FIRST
            && {araddr[11:2], 2'h0} != DMAS_AUTH_STATUS_OFFSET)
        |=> rvalid && rdata == 32'h00000000)
        else $error("reserved location read non-zero");

    AST_AUTH_READ: assert property (
        (arvalid && arready
            && {araddr[11:2], 2'h0} == DMAS_AUTH_STATUS_OFFSET)
        |=> rvalid && rdata == $past(st.authentication_status))
        else $error("status read does not return live status");

    AST_WRITE_ANSWER: assert property (
        (awvalid && awready && wvalid && wready) |=> bvalid
            && bresp == respFor($past(awaddr)))
        else $error("write response missing or wrong");

    AST_RESERVED_TOP: assert property (
        st.authentication_status[31:DMAS_RESERVED_LSB] == 4'h0)
        else $error("reserved status bits non-zero");

    AST_CHANGE_SEEN: assert property (
        $changed(debugEnable & FIELD_IMPL) ##1 $stable(debugEnable) [*4]
        |-> st.authentication_status != $past(st.authentication_status, 4)
            || FIELD_IMPL == 8'h00)
        else $error("enable change not reflected in status");

    AST_ROOT_NONINV: assert property (
        $stable(debugEnable[7]) [*5] ##0 $past(rst_b, 4)
        |-> st.authentication_status[27:26] ==
        (FIELD_IMPL[7] ? {1'b1, debugEnable[7]} : DMAS_CODE_ABSENT))
        else $error("root non-invasive code wrong");

    AST_ROOT_INV: assert property (
        $stable(debugEnable[6]) [*5] ##0 $past(rst_b, 4)
        |-> st.authentication_status[25:24] ==
        (FIELD_IMPL[6] ? {1'b1, debugEnable[6]} : DMAS_CODE_ABSENT))
        else $error("root invasive code wrong");

    AST_SEC_NONINV: assert property (
        st.authentication_status[23:22] != DMAS_CODE_RESERVED
        and ($stable(debugEnable[5]) [*5] ##0 $past(rst_b, 4)
        |-> st.authentication_status[23:22] ==
        (FIELD_IMPL[5] ? {1'b1, debugEnable[5]} : DMAS_CODE_ABSENT)))
        else $error("secure non-invasive code wrong");

    AST_SEC_INV: assert property (
        $stable(debugEnable[4]) [*5] ##0 $past(rst_b, 4)
        |-> st.authentication_status[21:20] ==
        (FIELD_IMPL[4] ? {1'b1, debugEnable[4]} : DMAS_CODE_ABSENT))
        else $error("secure invasive code wrong");

    AST_NSEC_NONINV: assert property (
        $stable(debugEnable[3]) [*5] ##0 $past(rst_b, 4)
        |-> st.authentication_status[19:18] ==
        (FIELD_IMPL[3] ? {1'b1, debugEnable[3]} : DMAS_CODE_ABSENT))
        else $error("non-secure non-invasive code wrong");

    AST_NSEC_INV: assert property (
        $stable(debugEnable[2]) [*5] ##0 $past(rst_b, 4)
        |-> st.authentication_status[17:16] ==
        (FIELD_IMPL[2] ? {1'b1, debugEnable[2]} : DMAS_CODE_ABSENT))
        else $error("non-secure invasive code wrong");

    AST_REALM_NONINV: assert property (
        $stable(debugEnable[1]) [*5] ##0 $past(rst_b, 4)
        |-> st.authentication_status[15:14] ==
        (FIELD_IMPL[1] ? {1'b1, debugEnable[1]} : DMAS_CODE_ABSENT))
        else $error("realm non-invasive code wrong");

    AST_REALM_INV: assert property (
        $stable(debugEnable[0]) [*5] ##0 $past(rst_b, 4)
        |-> st.authentication_status[13:12] ==
        (FIELD_IMPL[0] ? {1'b1, debugEnable[0]} : DMAS_CODE_ABSENT))
        else $error("realm invasive code wrong");

    // no field ever shows the reserved code 0b01
    AST_NO_RESERVED_CODE: assert property (
        (st.authentication_status[27:12] & 16'h5555
            & ~((st.authentication_status[27:12] >> 1) & 16'h5555)) == 16'h0000)
        else $error("reserved field code reported");

    AST_LOW_BITS_ZERO: assert property (
        st.authentication_status[11:0] == 12'h000)
        else $error("status bits below the fields non-zero");

    AST_PART_HELD: assert property (
        $past(rst_b) |-> partNumber == PART_NUMBER)
        else $error("part number not held");

    AST_READ_ANSWER: assert property (
        (arvalid && arready) |=> rvalid)
        else $error("read not answered next cycle");

    AST_LOW_READ: assert property (
        (arvalid && arready && araddr < DMAS_MGMT_FIRST)
        |=> rresp == DMAS_RESP_SLVERR && rdata == 32'h00000000)
        else $error("read below management range wrong");

    AST_RVALID_STAND: assert property (
        (rvalid && !rready) |=> rvalid && $stable(rdata) && $stable(rresp))
        else $error("read answer dropped before taken");

    AST_BVALID_STAND: assert property (
        (bvalid && !bready) |=> bvalid && $stable(bresp))
        else $error("write answer dropped before taken");

    AST_AR_BLOCKED: assert property (
        rvalid |-> !arready)
        else $error("read address taken while answer pending");

    AST_AW_BLOCKED: assert property (
        bvalid |-> !awready && !wready)
        else $error("write taken while answer pending");
endmodule

/* sim/debug_mgmt_auth_status_regs_tb_top.sv */
// self-checking bench for the management and status register bank
`timescale 1ns/1ns
module debug_mgmt_auth_status_regs_tb_top
    import dmas_pkg::*;
;
localparam logic [7:0] IMPL_MASK = 8'h7E;
// arbitrary part number value
localparam logic [11:0] PART_ID = 12'h3C7;
localparam int CYCLE_LIMIT = 6000;
logic clk = 1'b0;
logic rst_b = 1'b0;
logic [7:0] debugEnable = 8'h00;
logic [11:0] awaddr = 12'h000;
logic [11:0] araddr = 12'h000;
logic [31:0] wdata = 32'h00000000;
logic [3:0] wstrb = 4'h0;
logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
logic arvalid = 1'b0, rready = 1'b0;
logic awready, wready, bvalid, arready, rvalid;
logic [1:0] bresp, rresp;
logic [31:0] rdata;
logic [3:0] componentClass;
logic [11:0] partNumber;
int badCount = 0, compares = 0, cycles = 0;
integer seed = 32'h3D59;
logic [31:0] rd;
logic [1:0] rr;
logic [7:0] en;
logic [11:0] adr;

always #5 clk = ~clk;

dmas_regs #(.FIELD_IMPL(IMPL_MASK), .PART_NUMBER(PART_ID)) dut_u
(
    .clk(clk), .rst_b(rst_b), .debugEnable(debugEnable),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .componentClass(componentClass), .partNumber(partNumber)
);

function automatic logic [31:0] expStatus(input logic [7:0] e);
    logic [31:0] v;
    v = 32'h00000000;
    for (int i = 0; i < 8; i++)
        if (IMPL_MASK[i])
            v[12 + 2 * i +: 2] = {1'b1, e[i]};
    return v;
endfunction

task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
        badCount++;
        $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
endtask

task automatic closeOut();
    $display("Counts: %0d compares, %0d mismatches", compares, badCount);
    if (badCount == 0 && compares > 0)
        $display("All checks passed");
    else
        $display("Checks failed");
    $finish;
endtask

task automatic axiRead(input logic [11:0] a, output logic [31:0] d,
                       output logic [1:0] r);
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(negedge clk); while (arready !== 1'b1);
    @(posedge clk);
    arvalid <= 1'b0;
    do @(negedge clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    @(posedge clk);
    rready <= 1'b0;
endtask

task automatic axiWrite(input logic [11:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    logic pa, pw, ta, tw;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge clk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    bready <= 1'b1;
    while (pa || pw)
    begin
        @(negedge clk);
        ta = pa && (awready === 1'b1);
        tw = pw && (wready === 1'b1);
        @(posedge clk);
        if (ta)
            awvalid <= 1'b0;
        if (tw)
            wvalid <= 1'b0;
        pa = pa && !ta;
        pw = pw && !tw;
    end
    do @(negedge clk); while (bvalid !== 1'b1);
    r = bresp;
    @(posedge clk);
    bready <= 1'b0;
endtask

always @(posedge clk)
begin
    cycles <= cycles + 1;
    if (cycles == CYCLE_LIMIT)
    begin
        badCount = badCount + 1;
        closeOut();
    end
end

initial
begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    check(32'(componentClass), 32'(DMAS_COMPONENT_CLASS));
    check(32'(partNumber), 32'(PART_ID));
    $display("test identity done");
    for (int k = 0; k < 20; k++)
    begin
        en = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($random(seed));
        @(posedge clk);
        debugEnable <= en;
        repeat (6) @(posedge clk);
        axiRead(DMAS_AUTH_STATUS_OFFSET, rd, rr);
        check(rd, expStatus(en));
        check(rd, expStatus(en));
        check(32'(rr), 32'(DMAS_RESP_OKAY));
        axiWrite(DMAS_AUTH_STATUS_OFFSET, $random(seed), rr);
        check(32'(rr), 32'(DMAS_RESP_OKAY));
        axiRead(DMAS_AUTH_STATUS_OFFSET, rd, rr);
        check(rd, expStatus(en));
    end
    $display("test status fields done");
    for (int k = 0; k < 64; k++)
    begin
        adr = 12'hF00 + 12'(4 * k);
        if (adr != DMAS_AUTH_STATUS_OFFSET)
        begin
            axiWrite(adr, $random(seed), rr);
            check(32'(rr), 32'(DMAS_RESP_OKAY));
            axiRead(adr, rd, rr);
            check(rd, 32'h00000000);
            check(32'(rr), 32'(DMAS_RESP_OKAY));
        end
    end
    axiRead(DMAS_AUTH_STATUS_OFFSET, rd, rr);
    check(rd, expStatus(en));
    $display("test management range done");
    for (int k = 0; k < 8; k++)
    begin
        adr = (k == 0) ? 12'h000 : (k == 1) ? 12'hEFC :
              12'($unsigned($random(seed)) % 32'hF00);
        axiWrite(adr, $random(seed), rr);
        check(32'(rr), 32'(DMAS_RESP_SLVERR));
        axiRead(adr, rd, rr);
        check(rd, 32'h00000000);
        check(32'(rr), 32'(DMAS_RESP_SLVERR));
    end
    $display("test low addresses done");
    closeOut();
end
endmodule
